// ### hw/misc_control_and_driver_status.sv
// Miscellaneous control and driver-enable status registers.
// Assumes a synchronous 8-bit host register port and a sequencer write port.
`timescale 1ns/1ps
module misc_control_and_driver_status (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host register port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Sequencer register port
  input wire logic seq_wr,
  input wire logic [7:0] seq_addr,
  input wire logic [7:0] seq_wdata,
  // Driver-enable control bit held elsewhere
  input wire logic driver_enable_control,
  // Pin levels
  input wire logic soc_reset_pin_level,
  input wire logic general_reset_pin_level,
  input wire logic driver_enable_pin_level,
  // External clock monitor
  input wire logic external_clock_present,
  input wire logic external_clock_in_range,
  // Outputs
  output logic sync_clock_output,
  output logic soc_reset_out_level,
  output logic general_reset_out_level,
  output logic driver_enable_pin,
  output logic reference_output_enable,
  output logic use_external_clock,
  output logic external_clock_fault_irq,
  output logic clock_monitor_active,
  output logic thermal_cycling_active,
  output logic crc_checking_active,
  output logic identity_polling_active,
  output logic bus_watchdog_active,
  output logic digital_oscillator_stop,
  output logic driver_enable_control_effective
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] misc_control_reg;
  logic [7:0] status_store_reg;
  logic sync_raw;
  logic [7:0] status_view;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      misc_control_reg <= misc_ctrl_pkg::MISC_CONTROL_RESET;
    end else if (seq_wr && seq_addr == misc_ctrl_pkg::MISC_CONTROL_OFFSET) begin
      misc_control_reg <= seq_wdata;
    end else if (host_wr && host_addr == misc_ctrl_pkg::MISC_CONTROL_OFFSET) begin
      misc_control_reg <= host_wdata;
    end
  end

  // Host writes reach only the reserved bits; the sequencer owns bits 4 and 3.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_store_reg <= misc_ctrl_pkg::DRIVER_ENABLE_STATUS_RESET;
    end else if (seq_wr && seq_addr == misc_ctrl_pkg::DRIVER_ENABLE_STATUS_OFFSET) begin
      status_store_reg[7:3] <= seq_wdata[7:3];
    end else if (host_wr && host_addr == misc_ctrl_pkg::DRIVER_ENABLE_STATUS_OFFSET) begin
      status_store_reg[misc_ctrl_pkg::RESERVED_HI:misc_ctrl_pkg::RESERVED_LO] <=
        host_wdata[misc_ctrl_pkg::RESERVED_HI:misc_ctrl_pkg::RESERVED_LO];
    end
  end

  assign status_view = {status_store_reg[7:3],
                        soc_reset_pin_level,
                        general_reset_pin_level,
                        driver_enable_pin_level};

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      if (host_addr == misc_ctrl_pkg::MISC_CONTROL_OFFSET) begin
        host_rdata <= misc_control_reg;
      end else if (host_addr == misc_ctrl_pkg::DRIVER_ENABLE_STATUS_OFFSET) begin
        host_rdata <= status_view;
      end else begin
        host_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sync clock output
  // ---------------------------------------------------------------------------
  sync_clock_divider u_divider (
    .clk(clk),
    .arst_n(arst_n),
    .freq_select(misc_control_reg[misc_ctrl_pkg::FREQ_SEL_HI:misc_ctrl_pkg::FREQ_SEL_LO]),
    .clock_out(sync_raw)
  );

  // ---------------------------------------------------------------------------
  // Pin-level outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_clock_output <= 1'b0;
    end else begin
      sync_clock_output <= sync_raw;
    end
  end

  // Reset outputs follow their control bits directly, with no sequencing here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soc_reset_out_level <= 1'b0;
      general_reset_out_level <= 1'b0;
    end else begin
      soc_reset_out_level <= misc_control_reg[misc_ctrl_pkg::SOC_RESET_BIT];
      general_reset_out_level <= misc_control_reg[misc_ctrl_pkg::GEN_RESET_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reference_output_enable <= 1'b0;
    end else begin
      reference_output_enable <= misc_control_reg[misc_ctrl_pkg::REF_OUT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // External clock selection
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      use_external_clock <= 1'b0;
    end else begin
      use_external_clock <= misc_control_reg[misc_ctrl_pkg::EXT_CLK_SEL_BIT] &&
                            external_clock_present && external_clock_in_range;
    end
  end

  // The fault is a level, not a sticky flag: it drops once the clock is back in range.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      external_clock_fault_irq <= 1'b0;
    end else begin
      external_clock_fault_irq <= misc_control_reg[misc_ctrl_pkg::EXT_CLK_SEL_BIT] &&
        (!external_clock_present || !external_clock_in_range);
    end
  end

  // ---------------------------------------------------------------------------
  // Low power gating
  // ---------------------------------------------------------------------------
  // Clock monitoring needs its enable and the absence of low power mode.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_monitor_active <= 1'b0;
    end else begin
      clock_monitor_active <= misc_control_reg[misc_ctrl_pkg::CLK_MON_EN_BIT] &&
                              !misc_control_reg[misc_ctrl_pkg::LOW_POWER_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thermal_cycling_active <= 1'b1;
      crc_checking_active <= 1'b1;
    end else begin
      thermal_cycling_active <= !misc_control_reg[misc_ctrl_pkg::LOW_POWER_BIT];
      crc_checking_active <= !misc_control_reg[misc_ctrl_pkg::LOW_POWER_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      digital_oscillator_stop <= 1'b0;
    end else begin
      digital_oscillator_stop <= misc_control_reg[misc_ctrl_pkg::LOW_POWER_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Bus low power
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      identity_polling_active <= 1'b1;
      bus_watchdog_active <= 1'b1;
    end else begin
      identity_polling_active <= !misc_control_reg[misc_ctrl_pkg::LOW_POWER_BIT] &&
        !status_store_reg[misc_ctrl_pkg::BUS_LOW_POWER_BIT];
      bus_watchdog_active <= !status_store_reg[misc_ctrl_pkg::BUS_LOW_POWER_BIT];
    end
  end

  // Driver-enable gating by the sequencer-owned force-low bit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      driver_enable_pin <= 1'b0;
      driver_enable_control_effective <= 1'b0;
    end else begin
      driver_enable_pin <= driver_enable_control &&
                           !status_store_reg[misc_ctrl_pkg::FORCE_LOW_BIT];
      driver_enable_control_effective <= driver_enable_control &&
                                         !status_store_reg[misc_ctrl_pkg::FORCE_LOW_BIT];
    end
  end

endmodule

// ### hw/misc_ctrl_pkg.sv
// Package of register offsets, field positions, reset values and clock figures
// for the miscellaneous control and driver-enable status bank.
// Assumes an 8-bit register port with byte addresses and a 25 MHz system clock.
package misc_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MISC_CONTROL_OFFSET = 8'h81;
  localparam logic [7:0] DRIVER_ENABLE_STATUS_OFFSET = 8'h82;
  localparam logic [7:0] DRIVER_ENABLE_CONTROL_OFFSET = 8'h80;
  localparam logic [7:0] MISC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DRIVER_ENABLE_STATUS_RESET = 8'h08;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int FREQ_SEL_HI = 7;
  localparam int FREQ_SEL_LO = 6;
  localparam int EXT_CLK_SEL_BIT = 5;
  localparam int REF_OUT_EN_BIT = 4;
  localparam int CLK_MON_EN_BIT = 3;
  localparam int LOW_POWER_BIT = 2;
  localparam int SOC_RESET_BIT = 1;
  localparam int GEN_RESET_BIT = 0;
  localparam int BUS_LOW_POWER_BIT = 4;
  localparam int FORCE_LOW_BIT = 3;
  localparam int SOC_READBACK_BIT = 2;
  localparam int GEN_READBACK_BIT = 1;
  localparam int DRV_READBACK_BIT = 0;
  localparam int RESERVED_HI = 7;
  localparam int RESERVED_LO = 5;

  // ---------------------------------------------------------------------------
  // Sync clock output divider
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SYNC_1M1_HZ = 1100000;
  localparam int SYNC_2M2_HZ = 2200000;
  localparam int SYNC_4M4_HZ = 4400000;
  // Half-period counts, rounded down; the output is approximate at this clock rate.
  localparam logic [4:0] HALF_1M1 = 5'(CLK_HZ / (2 * SYNC_1M1_HZ));
  localparam logic [4:0] HALF_2M2 = 5'(CLK_HZ / (2 * SYNC_2M2_HZ));
  localparam logic [4:0] HALF_4M4 = 5'(CLK_HZ / (2 * SYNC_4M4_HZ));

  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_1M1 = 2'b01,
    SYNC_2M2 = 2'b10,
    SYNC_4M4 = 2'b11
  } sync_sel_t;

endpackage

// ### hw/sync_clock_divider.sv
// Divider producing the sync clock output from the system clock.
// Assumes the selection input is a register and changes rarely.
`timescale 1ns/1ps
module sync_clock_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic [1:0] freq_select,
  // Output
  output logic clock_out
);

  logic [4:0] count_reg;
  logic [4:0] half_limit;

  always_comb begin
    unique case (misc_ctrl_pkg::sync_sel_t'(freq_select))
      misc_ctrl_pkg::SYNC_OFF: half_limit = misc_ctrl_pkg::HALF_1M1;
      misc_ctrl_pkg::SYNC_1M1: half_limit = misc_ctrl_pkg::HALF_1M1;
      misc_ctrl_pkg::SYNC_2M2: half_limit = misc_ctrl_pkg::HALF_2M2;
      misc_ctrl_pkg::SYNC_4M4: half_limit = misc_ctrl_pkg::HALF_4M4;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 5'h00;
      clock_out <= 1'b0;
    end else if (freq_select == misc_ctrl_pkg::SYNC_OFF) begin
      count_reg <= 5'h00;
      clock_out <= 1'b0;
    end else if (count_reg >= half_limit - 5'h01) begin
      count_reg <= 5'h00;
      clock_out <= ~clock_out;
    end else begin
      count_reg <= count_reg + 5'h01;
    end
  end

endmodule

// ### testbench/misc_ctrl_props.sv
// Checker for the control and driver-enable status bank, seeing only top ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module misc_ctrl_props (
  // Clock, reset, host port and sequencer write strobe
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic seq_wr,
  // Inputs and outputs watched
  input wire logic driver_enable_control,
  input wire logic soc_reset_pin_level,
  input wire logic general_reset_pin_level,
  input wire logic driver_enable_pin_level,
  input wire logic external_clock_present,
  input wire logic external_clock_in_range,
  input wire logic soc_reset_out_level,
  input wire logic general_reset_out_level,
  input wire logic use_external_clock,
  input wire logic external_clock_fault_irq,
  input wire logic clock_monitor_active,
  input wire logic thermal_cycling_active,
  input wire logic identity_polling_active,
  input wire logic bus_watchdog_active,
  input wire logic digital_oscillator_stop,
  input wire logic driver_enable_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence ctrl_wr_alone;
    host_wr && host_addr == 8'h81 && !seq_wr ##1 !host_wr && !seq_wr;
  endsequence
  a_soc_reset_follow: assert property (ctrl_wr_alone |=>
    soc_reset_out_level == $past(host_wdata[1], 2)) else $error("soc reset level wrong");
  a_gen_reset_follow: assert property (ctrl_wr_alone |=>
    general_reset_out_level == $past(host_wdata[0], 2)) else $error("reset level wrong");
  a_pin_readback: assert property (host_rd && host_addr == 8'h82 |=> host_rdata[2:0] ==
    $past({soc_reset_pin_level, general_reset_pin_level, driver_enable_pin_level}))
    else $error("pin readback wrong");
  a_unmapped_zero: assert property (host_rd && host_addr > 8'h82 |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_cause: assert property (external_clock_fault_irq |-> !use_external_clock &&
    $past(!external_clock_present || !external_clock_in_range)) else $error("bad irq");
  a_ext_use_cause: assert property (use_external_clock |->
    $past(external_clock_present && external_clock_in_range)) else $error("bad clock use");
  a_drv_pin_cause: assert property (driver_enable_pin |-> $past(driver_enable_control))
    else $error("driver pin high without control");
  a_low_power_stop: assert property (digital_oscillator_stop |-> !clock_monitor_active &&
    !thermal_cycling_active && !identity_polling_active) else $error("low power leak");
  a_watchdog_gate: assert property (identity_polling_active |-> bus_watchdog_active)
    else $error("polling without watchdog");
  c_irq: cover property (external_clock_fault_irq);
  c_drv: cover property (driver_enable_pin);
  c_stop: cover property (digital_oscillator_stop);
  c_bus_quiet: cover property (!bus_watchdog_active);
endmodule
bind misc_control_and_driver_status misc_ctrl_props u_props (.clk(clk), .arst_n(arst_n),
  .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .seq_wr(seq_wr), .driver_enable_control(driver_enable_control),
  .soc_reset_pin_level(soc_reset_pin_level), .general_reset_pin_level(general_reset_pin_level),
  .driver_enable_pin_level(driver_enable_pin_level), .external_clock_present(external_clock_present),
  .external_clock_in_range(external_clock_in_range), .soc_reset_out_level(soc_reset_out_level),
  .general_reset_out_level(general_reset_out_level), .use_external_clock(use_external_clock),
  .external_clock_fault_irq(external_clock_fault_irq), .clock_monitor_active(clock_monitor_active),
  .thermal_cycling_active(thermal_cycling_active), .bus_watchdog_active(bus_watchdog_active),
  .identity_polling_active(identity_polling_active), .driver_enable_pin(driver_enable_pin),
  .digital_oscillator_stop(digital_oscillator_stop));

// ### testbench/tb.sv
// Self-checking bench with a byte-level model of both registers.
// Assumes the bank's registered outputs and one-cycle read latency.
`timescale 1ns/1ps
module tb;
  logic clk, arst_n, hw, hr, sw, dc, sp, gp, dp, p, r, so, so_prev;
  logic [7:0] ha, hd, sa, sd, rd;
  logic [12:0] got;
  int ctrl, stat, err_total, num_checks, op, cnt;
  int cnt_half[4] = '{1, int'(misc_ctrl_pkg::HALF_1M1), int'(misc_ctrl_pkg::HALF_2M2),
    int'(misc_ctrl_pkg::HALF_4M4)};
  misc_control_and_driver_status dut (.clk(clk), .arst_n(arst_n), .host_wr(hw), .host_rd(hr),
    .host_addr(ha), .host_wdata(hd), .host_rdata(rd), .seq_wr(sw), .seq_addr(sa), .seq_wdata(sd),
    .driver_enable_control(dc), .soc_reset_pin_level(sp), .general_reset_pin_level(gp),
    .driver_enable_pin_level(dp), .external_clock_present(p), .external_clock_in_range(r),
    .sync_clock_output(so), .soc_reset_out_level(got[10]), .general_reset_out_level(got[9]),
    .driver_enable_pin(got[1]), .reference_output_enable(got[8]), .use_external_clock(got[12]),
    .external_clock_fault_irq(got[11]), .clock_monitor_active(got[4]),
    .thermal_cycling_active(got[6]), .crc_checking_active(got[5]),
    .identity_polling_active(got[3]), .bus_watchdog_active(got[2]),
    .digital_oscillator_stop(got[7]), .driver_enable_control_effective(got[0]));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk(string n, logic [12:0] e, logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task read(logic [7:0] a, logic [7:0] e);
    hr = 1;
    ha = a;
    step(1);
    hr = 0;
    chk("read data", {5'h00, e}, {5'h00, rd});
    step(1);
  endtask
  task check_all();
    chk("outputs", {ctrl[5] & p & r, ctrl[5] & !(p & r), ctrl[1], ctrl[0], ctrl[4], ctrl[2],
      !ctrl[2], !ctrl[2], ctrl[3] & !ctrl[2], !ctrl[2] & !stat[4], !stat[4],
      dc & !stat[3], dc & !stat[3]}, got);
    read(8'h81, 8'(ctrl));
    read(8'h82, {8'(stat) & 8'hF8} | {5'h00, sp, gp, dp});
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    give_verdict();
  end
  initial begin
    {arst_n, hw, hr, sw, dc, sp, gp, dp, p, r, ha, hd, sa, sd} = '0;
    ctrl = 0;
    stat = 8'h08;
    void'($urandom(74246));
    step(2);
    arst_n = 1;
    check_all();
    sw = 1;
    sa = 8'h82;
    sd = 8'h10;
    stat = 8'h10;
    step(1);
    sw = 0;
    step(1);
    check_all();
    for (int i = 0; i < 60; i++) begin
      op = $urandom_range(3);
      {dc, sp, gp, dp, p, r} = 6'($urandom);
      hd = 8'($urandom);
      sd = 8'($urandom);
      ha = op[0] ? 8'h82 : 8'h81;
      sa = ha;
      hw = !op[1];
      sw = op[1];
      if (op == 0 || op == 2) ctrl = op[1] ? sd : hd;
      if (op == 1) stat = (hd & 8'hE0) | (stat & 8'h18);
      if (op == 3) stat = sd & 8'hF8;
      step(1);
      {hw, sw} = 2'b00;
      step(1);
      check_all();
      read(8'h90 + 8'(op), 8'h00);
    end
    foreach (cnt_half[k]) begin
      hd = 8'(k << 6);
      hw = 1;
      ha = 8'h81;
      step(1);
      hw = 0;
      step(3);
      cnt = 0;
      so_prev = so;
      repeat (220) begin
        step(1);
        if (so && !so_prev) cnt++;
        so_prev = so;
      end
      op = k == 0 ? 0 : 220 / (2 * cnt_half[k]);
      chk("sync edges", 13'(op), 13'((cnt - op) inside {[-1:1]} ? op : cnt));
    end
    give_verdict();
  end
endmodule
